// file: vim_map.vh
// Constants for the virtual input function mapper: register indices,
// field widths, function codes and function vector positions.
// Assumes an APB slave whose byte address is four times the index.
//
// Functional notes
// - Code 0 does nothing, 1 is servo enable, 2 is alarm reset.
// - Code 5 is reference direction; 6 to 9 are index bits 0 to 3.
// - Code 14 is positive travel limit, 15 negative travel limit.
// - Code 18 forward jog, 19 reverse jog, 24 gear ratio select.
// - Code 28 multi-position enable, 31 home switch.
// - Code 34 emergency stop, 40 multi-speed enable; 40 is the largest.
// - Trigger mode 0: function active while the written bit is 1.
// - Trigger mode 1: function fires only on a written 0-to-1 change.
// - Virtual inputs form one 16-bit word, bit 0 is input 1.
`ifndef VIM_MAP_VH
`define VIM_MAP_VH

// Register indices (byte address is four times the index).
`define VIM_IDX_IN3_FUNC     14'h1704
`define VIM_IDX_IN3_TRIG     14'h1705
`define VIM_IDX_IN4_FUNC     14'h1706
`define VIM_IDX_IN4_TRIG     14'h1707
`define VIM_IDX_IN5_FUNC     14'h1708
`define VIM_IDX_IN5_TRIG     14'h1709
`define VIM_IDX_IN6_FUNC     14'h170A
`define VIM_IDX_IN6_TRIG     14'h170B
`define VIM_IDX_IN7_FUNC     14'h170C
`define VIM_IDX_IN7_TRIG     14'h170D
`define VIM_IDX_IN8_FUNC     14'h170E
`define VIM_IDX_IN8_TRIG     14'h170F
`define VIM_IDX_IN9_FUNC     14'h1710
`define VIM_IDX_IN9_TRIG     14'h1711
`define VIM_IDX_WORD         14'h1720
`define VIM_IDX_STATUS       14'h1721
`define VIM_IDX_STRIDE       14'h0002

// Slots, widths and reset values.
`define VIM_SLOTS            7
`define VIM_FIRST_BIT        2
`define VIM_FUNC_W           6
`define VIM_FUNC_MAX         16'h0028
`define VIM_TRIG_MAX         16'h0001
`define VIM_FUNC_RST         6'h00
`define VIM_TRIG_RST         1'b0
`define VIM_WORD_RST         16'h0000
`define VIM_NFUNC            16

// Function codes.
`define VIM_CODE_NONE        6'h00
`define VIM_CODE_SERVO_ON    6'h01
`define VIM_CODE_ALARM_RST   6'h02
`define VIM_CODE_REF_DIR     6'h05
`define VIM_CODE_REF_IDX0    6'h06
`define VIM_CODE_REF_IDX1    6'h07
`define VIM_CODE_REF_IDX2    6'h08
`define VIM_CODE_REF_IDX3    6'h09
`define VIM_CODE_POS_LIMIT   6'h0E
`define VIM_CODE_NEG_LIMIT   6'h0F
`define VIM_CODE_JOG_FWD     6'h12
`define VIM_CODE_JOG_REV     6'h13
`define VIM_CODE_GEAR_SEL    6'h18
`define VIM_CODE_MULTIPOS    6'h1C
`define VIM_CODE_HOME_SW     6'h1F
`define VIM_CODE_ESTOP       6'h22
`define VIM_CODE_MSPEED      6'h28

// Positions in the function vector and the status register.
`define VIM_FN_SERVO_ON      0
`define VIM_FN_ALARM_RST     1
`define VIM_FN_REF_DIR       2
`define VIM_FN_REF_IDX0      3
`define VIM_FN_REF_IDX1      4
`define VIM_FN_REF_IDX2      5
`define VIM_FN_REF_IDX3      6
`define VIM_FN_POS_LIMIT     7
`define VIM_FN_NEG_LIMIT     8
`define VIM_FN_JOG_FWD       9
`define VIM_FN_JOG_REV       10
`define VIM_FN_GEAR_SEL      11
`define VIM_FN_MULTIPOS      12
`define VIM_FN_HOME_SW       13
`define VIM_FN_ESTOP         14
`define VIM_FN_MSPEED        15
`define VIM_STAT_RUN_BIT     16

`endif

// file: vim_slot.v
// One virtual input slot: decodes its function code and trigger mode
// into a one-hot vector of drive functions that this input asserts.
// Assumes the current and previous written bit come from registers.
`timescale 1ns/1ps
`include "vim_map.vh"

module vim_slot (
    // Configuration.
    input  wire [`VIM_FUNC_W-1:0] func_code,
    input  wire                   trig_mode,
    // Written input bit, now and one clock earlier.
    input  wire                   bit_now,
    input  wire                   bit_prev,
    // Function vector.
    output reg  [`VIM_NFUNC-1:0]  act_vec
);

    reg active;

    always @* begin
        if (trig_mode) begin
            active = bit_now & ~bit_prev;
        end else begin
            active = bit_now;
        end
        act_vec = {`VIM_NFUNC{1'b0}};
        case (func_code)
            `VIM_CODE_SERVO_ON:  act_vec[`VIM_FN_SERVO_ON]  = active;
            `VIM_CODE_ALARM_RST: act_vec[`VIM_FN_ALARM_RST] = active;
            `VIM_CODE_REF_DIR:   act_vec[`VIM_FN_REF_DIR]   = active;
            `VIM_CODE_REF_IDX0:  act_vec[`VIM_FN_REF_IDX0]  = active;
            `VIM_CODE_REF_IDX1:  act_vec[`VIM_FN_REF_IDX1]  = active;
            `VIM_CODE_REF_IDX2:  act_vec[`VIM_FN_REF_IDX2]  = active;
            `VIM_CODE_REF_IDX3:  act_vec[`VIM_FN_REF_IDX3]  = active;
            `VIM_CODE_POS_LIMIT: act_vec[`VIM_FN_POS_LIMIT] = active;
            `VIM_CODE_NEG_LIMIT: act_vec[`VIM_FN_NEG_LIMIT] = active;
            `VIM_CODE_JOG_FWD:   act_vec[`VIM_FN_JOG_FWD]   = active;
            `VIM_CODE_JOG_REV:   act_vec[`VIM_FN_JOG_REV]   = active;
            `VIM_CODE_GEAR_SEL:  act_vec[`VIM_FN_GEAR_SEL]  = active;
            `VIM_CODE_MULTIPOS:  act_vec[`VIM_FN_MULTIPOS]  = active;
            `VIM_CODE_HOME_SW:   act_vec[`VIM_FN_HOME_SW]   = active;
            `VIM_CODE_ESTOP:     act_vec[`VIM_FN_ESTOP]     = active;
            `VIM_CODE_MSPEED:    act_vec[`VIM_FN_MSPEED]    = active;
            // Code 0 and every unlisted code leave the vector clear.
            default:             act_vec = {`VIM_NFUNC{1'b0}};
        endcase
    end

endmodule

// file: vim_top.v
// Virtual input function mapper for inputs 3 to 9, with an APB slave
// holding the function and trigger mode of each input and the word.
// Assumes drive_running comes from drive logic on the same clock.
`timescale 1ns/1ps
`include "vim_map.vh"

module vim_top (
    // Clock and reset.
    input  wire        pclk,
    input  wire        presetn,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Drive state.
    input  wire        drive_running,
    // Drive function outputs.
    output wire        servo_on,
    output wire        alarm_reset,
    output wire        ref_dir,
    output wire        ref_index_bit0,
    output wire        ref_index_bit1,
    output wire        ref_index_bit2,
    output wire        ref_index_bit3,
    output wire        pos_limit,
    output wire        neg_limit,
    output wire        jog_fwd,
    output wire        jog_rev,
    output wire        gear_sel,
    output wire        multipos_en,
    output wire        home_switch,
    output wire        estop,
    output wire        multispeed_en
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    reg  [`VIM_FUNC_W-1:0]  func_reg [0:`VIM_SLOTS-1];
    reg                     trig_reg [0:`VIM_SLOTS-1];
    reg  [15:0]             word_reg;
    reg  [15:0]             prev_word_reg;
    reg  [`VIM_NFUNC-1:0]   fn_reg;
    reg  [31:0]             prdata_reg;
    reg                     pready_reg;
    reg                     pslverr_reg;

    reg  [31:0]             prdata_next;
    reg                     pslverr_next;
    reg  [`VIM_NFUNC-1:0]   fn_next;

    wire [13:0]             idx;
    wire                    aligned;
    wire                    setup;
    wire                    commit;
    wire [`VIM_NFUNC*`VIM_SLOTS-1:0] slot_vec;

    assign idx     = paddr[15:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup   = psel & ~penable;
    // A transfer commits only at the edge that samples pready high.
    assign commit  = psel & penable & pready_reg & pwrite & ~pslverr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Address decode and read data, evaluated in the setup cycle.

    always @* begin : decode
        integer k;
        reg [13:0] fidx;
        reg        hit;
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        hit          = 1'b0;
        fidx         = `VIM_IDX_IN3_FUNC;
        for (k = 0; k < `VIM_SLOTS; k = k + 1) begin
            if (idx == fidx) begin
                hit = 1'b1;
                prdata_next = {{(32-`VIM_FUNC_W){1'b0}}, func_reg[k]};
                if (pwrite && (pwdata[15:0] > `VIM_FUNC_MAX)) begin
                    pslverr_next = 1'b1;
                end
                if (pwrite && (pwdata[31:16] != 16'h0000)) begin
                    pslverr_next = 1'b1;
                end
            end
            if (idx == fidx + 14'h0001) begin
                hit = 1'b1;
                prdata_next = {31'h0000_0000, trig_reg[k]};
                if (pwrite && (pwdata[31:0] > {16'h0000, `VIM_TRIG_MAX})) begin
                    pslverr_next = 1'b1;
                end
            end
            fidx = fidx + `VIM_IDX_STRIDE;
        end
        if (idx == `VIM_IDX_WORD) begin
            hit = 1'b1;
            prdata_next = {16'h0000, word_reg};
        end
        if (idx == `VIM_IDX_STATUS) begin
            hit = 1'b1;
            prdata_next = {15'h0000, drive_running, fn_reg};
            if (pwrite) begin
                pslverr_next = 1'b1;
            end
        end
        if (!aligned || !hit) begin
            pslverr_next = 1'b1;
            prdata_next  = 32'h0000_0000;
        end
        if (pwrite) begin
            prdata_next = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: pready rises for the single access cycle of a transfer.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            if (setup) begin
                pslverr_reg <= pslverr_next;
                prdata_reg  <= prdata_next;
            end else if (penable && pready_reg) begin
                pslverr_reg <= 1'b0;
                prdata_reg  <= 32'h0000_0000;
            end
        end
    end

    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register writes.

    always @(posedge pclk or negedge presetn) begin : writes
        integer k;
        reg [13:0] fidx;
        if (!presetn) begin
            for (k = 0; k < `VIM_SLOTS; k = k + 1) begin
                func_reg[k] <= `VIM_FUNC_RST;
                trig_reg[k] <= `VIM_TRIG_RST;
            end
            word_reg <= `VIM_WORD_RST;
            fidx     = `VIM_IDX_IN3_FUNC;
        end else begin
            fidx = `VIM_IDX_IN3_FUNC;
            for (k = 0; k < `VIM_SLOTS; k = k + 1) begin
                if (commit && (idx == fidx)) begin
                    func_reg[k] <= pwdata[`VIM_FUNC_W-1:0];
                end
                // Changing the mode mid-motion could fire a stray edge.
                if (commit && (idx == fidx + 14'h0001) && !drive_running) begin
                    trig_reg[k] <= pwdata[0];
                end
                fidx = fidx + `VIM_IDX_STRIDE;
            end
            if (commit && (idx == `VIM_IDX_WORD)) begin
                word_reg <= pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slots for inputs 3 to 9.

    genvar g;
    generate
        for (g = 0; g < `VIM_SLOTS; g = g + 1) begin : slot
            vim_slot u_slot (
                .func_code (func_reg[g]),
                .trig_mode (trig_reg[g]),
                .bit_now   (word_reg[`VIM_FIRST_BIT+g]),
                .bit_prev  (prev_word_reg[`VIM_FIRST_BIT+g]),
                .act_vec   (slot_vec[`VIM_NFUNC*g +: `VIM_NFUNC])
            );
        end
    endgenerate

    // Several inputs mapped to one function combine as a logical OR.
    always @* begin : merge
        integer k;
        fn_next = {`VIM_NFUNC{1'b0}};
        for (k = 0; k < `VIM_SLOTS; k = k + 1) begin
            fn_next = fn_next | slot_vec[`VIM_NFUNC*k +: `VIM_NFUNC];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge memory and registered function outputs.

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_word_reg <= `VIM_WORD_RST;
            fn_reg        <= {`VIM_NFUNC{1'b0}};
        end else begin
            prev_word_reg <= word_reg;
            fn_reg        <= fn_next;
        end
    end

    assign servo_on       = fn_reg[`VIM_FN_SERVO_ON];
    assign alarm_reset    = fn_reg[`VIM_FN_ALARM_RST];
    assign ref_dir        = fn_reg[`VIM_FN_REF_DIR];
    assign ref_index_bit0 = fn_reg[`VIM_FN_REF_IDX0];
    assign ref_index_bit1 = fn_reg[`VIM_FN_REF_IDX1];
    assign ref_index_bit2 = fn_reg[`VIM_FN_REF_IDX2];
    assign ref_index_bit3 = fn_reg[`VIM_FN_REF_IDX3];
    assign pos_limit      = fn_reg[`VIM_FN_POS_LIMIT];
    assign neg_limit      = fn_reg[`VIM_FN_NEG_LIMIT];
    assign jog_fwd        = fn_reg[`VIM_FN_JOG_FWD];
    assign jog_rev        = fn_reg[`VIM_FN_JOG_REV];
    assign gear_sel       = fn_reg[`VIM_FN_GEAR_SEL];
    assign multipos_en    = fn_reg[`VIM_FN_MULTIPOS];
    assign home_switch    = fn_reg[`VIM_FN_HOME_SW];
    assign estop          = fn_reg[`VIM_FN_ESTOP];
    assign multispeed_en  = fn_reg[`VIM_FN_MSPEED];

endmodule

// file: vim_props.sv
// Bus and refusal checks on the mapper's top-level ports.
// Assumes one clock, pclk, and the active-low asynchronous presetn.
`timescale 1ns/1ps
module vim_props (
    // Clock and reset.
    input wire        pclk,
    input wire        presetn,
    // APB.
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
////////////////////////////////////////////////////////////////////////
    wire [13:0] idx = paddr[15:2];
    wire        sel = idx >= 14'h1704 && idx <= 14'h1711;
    wire        fsel = sel && !idx[0];
    wire        tsel = sel && idx[0];
    wire        wr = pready && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("no answer");
    property p_cause; pready |-> $past(psel && !penable); endproperty
    a_cause: assert property (p_cause) else $error("pready unasked");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("prdata not idle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr alone");
    property p_unal; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    a_unal: assert property (p_unal) else $error("unaligned taken");
    property p_fbig; wr && fsel && pwdata > 32'h28 |-> pslverr; endproperty
    a_fbig: assert property (p_fbig) else $error("code over 40");
    property p_tbig; wr && tsel && pwdata > 32'h1 |-> pslverr; endproperty
    a_tbig: assert property (p_tbig) else $error("mode over 1");
    property p_mode; wr && tsel && pwdata < 32'h2 |-> !pslverr; endproperty
    a_mode: assert property (p_mode) else $error("mode refused");
    property p_stat; wr && idx == 14'h1721 |-> pslverr; endproperty
    a_stat: assert property (p_stat) else $error("status written");
    c_wr: cover property (wr && !pslverr);
    c_rd: cover property (pready && !pwrite);
    c_err: cover property (pslverr);
endmodule
bind vim_top vim_props u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// file: vim_host.sv
// Host model: an APB master that maps functions and writes the word.
// Assumes pclk from the bench; waits on pready however late it comes.
`timescale 1ns/1ps
module vim_host (
    // Clock.
    input  wire        pclk,
    // APB.
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [15:0] paddr,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
////////////////////////////////////////////////////////////////////////
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task xfer(input w, input [15:0] a, input [31:0] d,
              output [31:0] r, output e);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // Released data is inverted so a stale value never looks valid.
        {psel, penable, pwdata} <= {2'b00, ~d};
        // One idle edge, so a following call never drives psel twice at once.
        @(posedge pclk);
    endtask
    // Map first, then raise the word, so a bit never meets a stale map.
    task drive_in(input int n, input [5:0] code, input [15:0] word);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, 16'h5C10 + 16'(8 * (n - 3)), {26'h0, code}, r, e);
        xfer(1'b1, 16'h5C80, {16'h0, word}, r, e);
    endtask
endmodule

// file: testbench.sv
// Self-checking bench for the virtual input function mapper.
// Assumes a 100 MHz pclk and the host model as the only bus master.
`timescale 1ns/1ps
module testbench;
    logic        pclk = 0, presetn = 0, drive_running = 0;
    wire         psel, penable, pwrite, pready, pslverr;
    wire  [15:0] paddr, fv;
    wire  [31:0] pwdata, prdata;
    int          bad_count = 0, checked = 0, n, cnt;
    logic [31:0] r;
    logic        e;
    logic [21:0] rows [19] = '{{6'h00, 16'h0000}, {6'h01, 16'h0001},
        {6'h02, 16'h0002}, {6'h05, 16'h0004}, {6'h06, 16'h0008},
        {6'h07, 16'h0010}, {6'h08, 16'h0020}, {6'h09, 16'h0040},
        {6'h0E, 16'h0080}, {6'h0F, 16'h0100}, {6'h12, 16'h0200},
        {6'h13, 16'h0400}, {6'h18, 16'h0800}, {6'h1C, 16'h1000},
        {6'h1F, 16'h2000}, {6'h22, 16'h4000}, {6'h28, 16'h8000},
        {6'h03, 16'h0000}, {6'h27, 16'h0000}};
    logic [46:0] refs [5] = '{{1'b1, 14'h1704, 32'h29},
        {1'b1, 14'h1706, 32'h10000}, {1'b1, 14'h1705, 32'h2},
        {1'b1, 14'h1721, 32'h0}, {1'b0, 14'h1700, 32'h0}};
////////////////////////////////////////////////////////////////////////
    always #5 pclk = ~pclk;
    vim_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    vim_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .drive_running,
        .servo_on(fv[0]), .alarm_reset(fv[1]), .ref_dir(fv[2]),
        .ref_index_bit0(fv[3]), .ref_index_bit1(fv[4]),
        .ref_index_bit2(fv[5]), .ref_index_bit3(fv[6]),
        .pos_limit(fv[7]), .neg_limit(fv[8]), .jog_fwd(fv[9]),
        .jog_rev(fv[10]), .gear_sel(fv[11]), .multipos_en(fv[12]),
        .home_switch(fv[13]), .estop(fv[14]), .multispeed_en(fv[15]));
    task cmp(input [31:0] got, input [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rw(input w, input [13:0] i, input [31:0] d);
        u_host.xfer(w, {i, 2'b00}, d, r, e);
    endtask
    task count_pulses;
        cnt = 0;
        repeat (6) begin
            @(posedge pclk);
            cnt += (fv[0] === 1'b1);
        end
    endtask
    task final_report;
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            rw(1'b0, 14'h1704 + 14'(i), 32'h0);
            cmp(r, 32'h0);
        end
        // Each row maps one code onto a rotating input and holds its bit.
        foreach (rows[i]) begin
            n = 3 + i % 7;
            u_host.drive_in(n, rows[i][21:16], 16'(1 << (n - 1)));
            repeat (2) @(posedge pclk);
            cmp(fv, rows[i][15:0]);
            rw(1'b0, 14'h1721, 32'h0);
            cmp(r, {16'h0, rows[i][15:0]});
            u_host.drive_in(n, 6'h00, 16'h0000);
        end
        rw(1'b1, 14'h1709, 32'h1);
        u_host.drive_in(5, 6'h01, 16'h0010);
        count_pulses;
        cmp(cnt, 1);
        rw(1'b1, 14'h1720, 32'h10);
        count_pulses;
        cmp(cnt, 0);
        drive_running <= 1'b1;
        rw(1'b1, 14'h1709, 32'h0);
        cmp(32'(e), 32'h0);
        rw(1'b0, 14'h1709, 32'h0);
        cmp(r, 32'h1);
        rw(1'b1, 14'h1708, 32'h2);
        rw(1'b0, 14'h1708, 32'h0);
        cmp(r, 32'h2);
        drive_running <= 1'b0;
        foreach (refs[i]) begin
            rw(refs[i][46], refs[i][45:32], refs[i][31:0]);
            cmp(32'(e), 32'h1);
        end
        rw(1'b0, 14'h1704, 32'h0);
        cmp(r, 32'h0);
        u_host.xfer(1'b0, 16'h5C12, 32'h0, r, e);
        cmp(32'(e), 32'h1);
        // A reset in mid-run must clear the map, the word and the outputs.
        u_host.drive_in(3, 6'h01, 16'h0004);
        repeat (2) @(posedge pclk);
        cmp(fv, 32'h1);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        cmp(fv, 32'h0);
        presetn <= 1'b1;
        rw(1'b0, 14'h1704, 32'h0);
        cmp(r, 32'h0);
        rw(1'b0, 14'h1720, 32'h0);
        cmp(r, 32'h0);
        repeat (2) @(posedge pclk);
        cmp(fv, 32'h0);
        final_report;
    end
endmodule
